// ---- anr_pkg.sv ----
// package: register indices, field positions, reset values and carrier types
package anr_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [15:0] ANR_IDX_PARTNER_ABILITY = 16'h010A;
    localparam logic [15:0] ANR_IDX_EXPANSION       = 16'h010C;
    localparam logic [15:0] ANR_IDX_NEXT_PAGE       = 16'h010E;
    localparam logic [15:0] ANR_IDX_IRQ_STATUS      = 16'h0120;
    localparam logic [15:0] ANR_IDX_IRQ_MASK        = 16'h0121;

    // partner base page ability field positions
    localparam int ANR_PA_NEXT_PAGE    = 15;
    localparam int ANR_PA_ACK          = 14;
    localparam int ANR_PA_REMOTE_FAULT = 13;
    localparam int ANR_PA_RSVD         = 12;

    // expansion status field positions
    localparam int ANR_EX_PAR_FAULT    = 4;
    localparam int ANR_EX_LP_NP_ABLE   = 3;
    localparam int ANR_EX_NP_ABLE      = 2;
    localparam int ANR_EX_PAGE_RX      = 1;
    localparam int ANR_EX_LP_AN_ABLE   = 0;

    // next page register field positions
    localparam int ANR_NP_NEXT_PAGE    = 15;
    localparam int ANR_NP_MSG_PAGE     = 13;
    localparam int ANR_NP_ACK2         = 12;
    localparam int ANR_NP_TOGGLE       = 11;
    localparam int ANR_NP_MSG_MSB      = 10;

    // reset values
    localparam logic        ANR_RST_NP_NEXT   = 1'b0;
    localparam logic        ANR_RST_NP_MSGPG  = 1'b1;
    localparam logic        ANR_RST_NP_ACK2   = 1'b0;
    localparam logic        ANR_RST_NP_TOGGLE = 1'b0;
    localparam logic [10:0] ANR_RST_NP_MSG    = 11'h001;
    localparam logic        ANR_LOCAL_NP_ABLE = 1'b1;

    // interrupt status bit positions
    localparam int ANR_IRQ_W           = 3;
    localparam int ANR_IRQ_PAGE_RX     = 0;
    localparam int ANR_IRQ_PAR_FAULT   = 1;
    localparam int ANR_IRQ_NP_SENT     = 2;

    // locally transmitted next page word as sent to the engine
    typedef struct packed {
        logic        next_page;
        logic        rsvd;
        logic        msg_page;
        logic        ack2;
        logic        toggle;
        logic [10:0] msg;
    } anr_np_word_t;

    // page received from the partner, with its kind
    typedef struct packed {
        logic        base;
        logic [15:0] word;
    } anr_rx_page_t;

endpackage

// ---- anr_lh_flag.sv ----
// latched-high status flag, cleared by a management read that returned it
module anr_lh_flag (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // condition and read strobe
    input  wire logic set_i,
    input  wire logic rd_clr_i,
    // latched flag
    output logic      flag_q
);
    // set wins over the read clear, so a condition still present stays visible
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (set_i) begin
            flag_q <= 1'b1;
        end else if (rd_clr_i) begin
            flag_q <= 1'b0;
        end
    end
endmodule

// ---- anr_irq.sv ----
// sticky event status with write-one-to-clear, mask and one level interrupt
module anr_irq #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // events from the block
    input  wire logic [W-1:0] evt_i,
    // software access
    input  wire logic         sts_wr_i,
    input  wire logic         msk_wr_i,
    input  wire logic [W-1:0] wdata_i,
    // state and interrupt
    output logic      [W-1:0] status_q,
    output logic      [W-1:0] mask_q,
    output logic              irq
);
    // per-bit sticky status; an event in the clearing cycle is kept
    for (genvar i = 0; i < W; i++) begin : g_sts
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                status_q[i] <= 1'b0;
            end else if (evt_i[i]) begin
                status_q[i] <= 1'b1;
            end else if (sts_wr_i && wdata_i[i]) begin
                status_q[i] <= 1'b0;
            end
        end
    end

    // mask register, one enables the bit onto the interrupt
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask_q <= '0;
        end else if (msk_wr_i) begin
            mask_q <= wdata_i;
        end
    end

    assign irq = |(status_q & mask_q);
endmodule

// ---- anr_regs.sv ----
// auto-negotiation partner, expansion and next page registers behind apb
//
// Notes on behaviour
// - ability bit 15 shows partner base page next page capability
// - ability bit 14 set once a partner code word arrived, zero before
// - ability bit 13 reports partner remote fault
// - ability bits 11:10 carry partner pause capability as received
// - ability bits 9..5 carry partner technology abilities
// - expansion bit 4 latches parallel detection fault until read
// - expansion bit 3 shows partner next page capability
// - expansion bit 2 always reads one, local next page able
// - expansion bit 1 latches new page received until read
// - expansion bit 0 shows partner auto-negotiation ability
// - next page bit 15, reset zero, host-written, sent in page
// - next page bit 13 message page, reset one; field 10:0 reset 0x001
// - next page bit 12 acknowledge 2, writable, reset zero
// - read-only toggle bit 11 holds previous transmitted toggle value
module anr_regs
    import anr_pkg::*;
#(
    parameter int APB_AW = 16
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_AW-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic      [31:0]           prdata,
    output logic                       pslverr,
    // auto-negotiation engine, same clock
    input  wire logic                  page_rx_stb,
    input  wire anr_pkg::anr_rx_page_t page_rx,
    input  wire logic                  par_fault_stb,
    input  wire logic                  partner_an_able,
    input  wire logic                  an_restart,
    input  wire logic                  np_sent_stb,
    // next page to transmit
    output anr_pkg::anr_np_word_t      np_tx_word,
    // interrupt
    output logic                       irq
);
    import anr_pkg::*;

    // decode
    logic [15:0]          word_idx;
    logic                 aligned;
    logic                 sel_pa;
    logic                 sel_ex;
    logic                 sel_np;
    logic                 sel_is;
    logic                 sel_im;
    logic                 hit;
    logic                 acc;
    logic                 wr_stb;
    logic                 rd_stb;
    logic                 setup;

    // partner state
    logic [15:0]          base_q;
    logic                 ack_q;

    // next page state
    logic                 np_next_q;
    logic                 np_msgpg_q;
    logic                 np_ack2_q;
    logic                 np_toggle_q;
    logic [10:0]          np_msg_q;

    // latched flags and interrupt state
    logic                 pdf_flag_q;
    logic                 prx_flag_q;
    logic                 pdf_clr;
    logic                 prx_clr;
    logic [ANR_IRQ_W-1:0] irq_evt;
    logic [ANR_IRQ_W-1:0] irq_sts;
    logic [ANR_IRQ_W-1:0] irq_msk;

    // read path
    logic [15:0]          pa_word;
    logic [15:0]          ex_word;
    logic [15:0]          np_word;
    logic [31:0]          rd_word;
    logic [31:0]          prdata_q;
    logic                 pslverr_rd;

    // word index from the byte address; low bits must be zero
    always_comb begin
        word_idx = '0;
        word_idx[APB_AW-3:0] = paddr[APB_AW-1:2];
        aligned  = (paddr[1:0] == 2'b00);
    end

    assign sel_pa = aligned && (word_idx == ANR_IDX_PARTNER_ABILITY);
    assign sel_ex = aligned && (word_idx == ANR_IDX_EXPANSION);
    assign sel_np = aligned && (word_idx == ANR_IDX_NEXT_PAGE);
    assign sel_is = aligned && (word_idx == ANR_IDX_IRQ_STATUS);
    assign sel_im = aligned && (word_idx == ANR_IDX_IRQ_MASK);
    assign hit    = sel_pa | sel_ex | sel_np | sel_is | sel_im;

    // zero wait states: every access ends in its first access cycle
    assign pready = 1'b1;
    assign setup  = psel & ~penable;
    assign acc    = psel & penable;
    assign wr_stb = acc & pwrite & hit;
    assign rd_stb = acc & ~pwrite & hit;

    // unmapped or misaligned addresses answer with an error
    assign pslverr_rd = acc & ~hit;
    assign pslverr    = pslverr_rd;

    // partner base page is captured only from base pages
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            base_q <= 16'h0000;
        end else if (an_restart) begin
            base_q <= 16'h0000;
        end else if (page_rx_stb && page_rx.base) begin
            base_q <= page_rx.word;
        end
    end

    // ack bit tracking
    // the first code word sets it; a restart of negotiation returns it to zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else if (page_rx_stb) begin
            ack_q <= 1'b1;
        end else if (an_restart) begin
            ack_q <= 1'b0;
        end
    end

    // partner ability word
    always_comb begin
        pa_word = base_q;
        pa_word[ANR_PA_NEXT_PAGE] = base_q[ANR_PA_NEXT_PAGE];
        pa_word[ANR_PA_ACK] = ack_q;
        pa_word[ANR_PA_REMOTE_FAULT] = base_q[ANR_PA_REMOTE_FAULT];
        pa_word[ANR_PA_RSVD] = 1'b0;
        // pause field as received, and ability flags as received
        pa_word[11:5] = base_q[11:5];
    end

    anr_lh_flag u_pdf (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .set_i    (par_fault_stb),
        .rd_clr_i (pdf_clr),
        .flag_q   (pdf_flag_q)
    );

    anr_lh_flag u_prx (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .set_i    (page_rx_stb),
        .rd_clr_i (prx_clr),
        .flag_q   (prx_flag_q)
    );

    // clear only what the read returned
    // the data word was taken in the setup cycle, so a flag that rose later
    // is not lost by this read
    assign pdf_clr = rd_stb & sel_ex & prdata_q[ANR_EX_PAR_FAULT];
    assign prx_clr = rd_stb & sel_ex & prdata_q[ANR_EX_PAGE_RX];

    // expansion status word
    always_comb begin
        ex_word = 16'h0000;
        ex_word[ANR_EX_PAR_FAULT] = pdf_flag_q;
        ex_word[ANR_EX_LP_NP_ABLE] = base_q[ANR_PA_NEXT_PAGE];
        ex_word[ANR_EX_NP_ABLE] = ANR_LOCAL_NP_ABLE;
        ex_word[ANR_EX_PAGE_RX] = prx_flag_q;
        ex_word[ANR_EX_LP_AN_ABLE] = partner_an_able;
    end

    // writable next page fields
    // toggle is not writable; the engine owns it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            np_next_q  <= ANR_RST_NP_NEXT;
            np_msgpg_q <= ANR_RST_NP_MSGPG;
            np_ack2_q  <= ANR_RST_NP_ACK2;
            np_msg_q   <= ANR_RST_NP_MSG;
        end else if (wr_stb && sel_np) begin
            np_next_q  <= pwdata[ANR_NP_NEXT_PAGE];
            np_msgpg_q <= pwdata[ANR_NP_MSG_PAGE];
            np_msg_q   <= pwdata[ANR_NP_MSG_MSB:0];
            np_ack2_q  <= pwdata[ANR_NP_ACK2];
        end
    end

    // toggle follows each transmitted word
    // the word on the wire carries the inverse of the previous toggle,
    // so after a send the register holds the value just transmitted
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            np_toggle_q <= ANR_RST_NP_TOGGLE;
        end else if (an_restart) begin
            np_toggle_q <= ANR_RST_NP_TOGGLE;
        end else if (np_sent_stb) begin
            np_toggle_q <= ~np_toggle_q;
        end
    end

    // next page word as read back
    always_comb begin
        np_word = 16'h0000;
        np_word[ANR_NP_NEXT_PAGE]     = np_next_q;
        np_word[ANR_NP_MSG_PAGE]      = np_msgpg_q;
        np_word[ANR_NP_ACK2]          = np_ack2_q;
        np_word[ANR_NP_TOGGLE]        = np_toggle_q;
        np_word[ANR_NP_MSG_MSB:0]     = np_msg_q;
    end

    // word handed to the engine for transmission
    assign np_tx_word.next_page = np_next_q;
    assign np_tx_word.rsvd      = 1'b0;
    assign np_tx_word.msg_page  = np_msgpg_q;
    assign np_tx_word.ack2      = np_ack2_q;
    assign np_tx_word.toggle    = ~np_toggle_q;
    assign np_tx_word.msg       = np_msg_q;

    // events that raise the interrupt
    always_comb begin
        irq_evt = '0;
        irq_evt[ANR_IRQ_PAGE_RX]   = page_rx_stb;
        irq_evt[ANR_IRQ_PAR_FAULT] = par_fault_stb;
        irq_evt[ANR_IRQ_NP_SENT]   = np_sent_stb;
    end

    anr_irq #(
        .W (ANR_IRQ_W)
    ) u_irq (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .evt_i    (irq_evt),
        .sts_wr_i (wr_stb & sel_is),
        .msk_wr_i (wr_stb & sel_im),
        .wdata_i  (pwdata[ANR_IRQ_W-1:0]),
        .status_q (irq_sts),
        .mask_q   (irq_msk),
        .irq      (irq)
    );

    // read mux; narrow registers read zero above their width
    always_comb begin
        rd_word = 32'h0000_0000;
        if (sel_pa) begin
            rd_word[15:0] = pa_word;
        end else if (sel_ex) begin
            rd_word[15:0] = ex_word;
        end else if (sel_np) begin
            rd_word[15:0] = np_word;
        end else if (sel_is) begin
            rd_word[ANR_IRQ_W-1:0] = irq_sts;
        end else if (sel_im) begin
            rd_word[ANR_IRQ_W-1:0] = irq_msk;
        end
    end

    // read data taken in the setup cycle so prdata comes from a flop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
        end
    end

    assign prdata = prdata_q;
endmodule

// ---- anr_engine_model.sv ----
// auto-negotiation engine stand-in: page, fault, next page sent and restart events
module anr_engine_model
    import anr_pkg::*;
(
    // clock
    input  wire logic                  clk_sys,
    // events toward the registers
    output logic                       page_rx_stb,
    output anr_pkg::anr_rx_page_t      page_rx,
    output logic                       par_fault_stb,
    output logic                       partner_an_able,
    output logic                       an_restart,
    output logic                       np_sent_stb,
    // next page word handed over and the copy sent
    input  wire anr_pkg::anr_np_word_t np_tx_word,
    output anr_pkg::anr_np_word_t      sent_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet lines at time zero
    initial begin
        page_rx_stb = 1'b0;
        page_rx = '0;
        par_fault_stb = 1'b0;
        partner_an_able = 1'b0;
        an_restart = 1'b0;
        np_sent_stb = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (np_sent_stb) begin
            sent_q <= np_tx_word;
        end
    end

    task automatic set_able(input logic v);
        partner_an_able <= v;
    endtask

    // page lines carry the inverse outside the strobe, never a stale copy
    task automatic send_page(input logic base, input logic [15:0] w);
        page_rx_stb <= 1'b1;
        page_rx     <= '{base, w};
        @(posedge clk_sys);
        page_rx_stb <= 1'b0;
        page_rx     <= '{~base, ~w};
    endtask

    // one-cycle pulse: 0 fault, 1 next page sent, 2 restart
    task automatic pulse(input int k);
        par_fault_stb <= (k == 0);
        np_sent_stb   <= (k == 1);
        an_restart    <= (k == 2);
        @(posedge clk_sys);
        par_fault_stb <= 1'b0;
        np_sent_stb   <= 1'b0;
        an_restart    <= 1'b0;
    endtask
endmodule

// ---- anr_regs_asserts.sv ----
// checker: register behaviour seen at the anr_regs ports
module anr_regs_asserts
    import anr_pkg::*;
#(
    parameter int APB_AW = 16
) (
    // clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [APB_AW-1:0]     paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  pready,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    // engine
    input wire logic                  page_rx_stb,
    input wire anr_pkg::anr_rx_page_t page_rx,
    input wire logic                  par_fault_stb,
    input wire logic                  partner_an_able,
    input wire logic                  an_restart,
    input wire logic                  np_sent_stb,
    input wire anr_pkg::anr_np_word_t np_tx_word,
    input wire logic                  irq
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [APB_AW-1:0] A_EX = APB_AW'(ANR_IDX_EXPANSION) << 2;
    localparam logic [APB_AW-1:0] A_NP = APB_AW'(ANR_IDX_NEXT_PAGE) << 2;

    // bus phase decode
    logic rd_set;
    logic rd_acc;
    logic wr_acc;
    assign rd_set = psel & ~penable & ~pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign wr_acc = psel & penable & pwrite;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_ex_setup; rd_set && paddr == A_EX; endsequence
    sequence s_page_then_read; page_rx_stb ##1 s_ex_setup; endsequence
    sequence s_fault_then_read; par_fault_stb ##1 s_ex_setup; endsequence

    property p_page_latch; s_page_then_read |=> prdata[1]; endproperty
    a_page_latch: assert property (p_page_latch) else $error("page flag not seen");
    property p_fault_latch; s_fault_then_read |=> prdata[4]; endproperty
    a_fault_latch: assert property (p_fault_latch) else $error("fault flag not seen");
    property p_ex_const;
        rd_acc && paddr == A_EX |-> prdata[2] && prdata[31:5] == 27'h0;
    endproperty
    a_ex_const: assert property (p_ex_const) else $error("expansion constant bits");
    property p_an_able;
        rd_acc && paddr == A_EX |-> prdata[0] == $past(partner_an_able);
    endproperty
    a_an_able: assert property (p_an_able) else $error("partner able bit");
    property p_tog_rd;
        rd_acc && paddr == A_NP |-> prdata[11] != $past(np_tx_word.toggle) && !prdata[14];
    endproperty
    a_tog_rd: assert property (p_tog_rd) else $error("toggle read mismatch");
    property p_tog_flip;
        np_sent_stb && !an_restart |=> np_tx_word.toggle != $past(np_tx_word.toggle);
    endproperty
    a_tog_flip: assert property (p_tog_flip) else $error("toggle did not flip");
    property p_np_write;
        wr_acc && paddr == A_NP |=> {np_tx_word.next_page, np_tx_word.msg_page,
            np_tx_word.ack2, np_tx_word.msg} == $past({pwdata[15], pwdata[13:12], pwdata[10:0]});
    endproperty
    a_np_write: assert property (p_np_write)
        else $error("next page write lost");
    property p_np_hold; !wr_acc && !np_sent_stb && !an_restart |=> $stable(np_tx_word); endproperty
    a_np_hold: assert property (p_np_hold) else $error("next page word moved");
endmodule

bind anr_regs anr_regs_asserts #(.APB_AW(APB_AW)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .page_rx_stb(page_rx_stb), .page_rx(page_rx), .par_fault_stb(par_fault_stb),
    .partner_an_able(partner_an_able), .an_restart(an_restart), .np_sent_stb(np_sent_stb),
    .np_tx_word(np_tx_word), .irq(irq)
);

// ---- tb_autoneg_partner_nextpage_regs.sv ----
// testbench: apb register tests against the engine stand-in
module tb_autoneg_partner_nextpage_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import anr_pkg::*;

    localparam logic [15:0] A_PA = ANR_IDX_PARTNER_ABILITY << 2;
    localparam logic [15:0] A_EX = ANR_IDX_EXPANSION << 2;
    localparam logic [15:0] A_NP = ANR_IDX_NEXT_PAGE << 2;
    localparam logic [15:0] A_IS = ANR_IDX_IRQ_STATUS << 2;
    localparam logic [15:0] A_IM = ANR_IDX_IRQ_MASK << 2;

    logic          clk_sys = 1'b0;
    logic          rst;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [15:0]   paddr;
    logic [31:0]   pwdata;
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    logic          page_rx_stb;
    anr_rx_page_t  page_rx;
    logic          par_fault_stb;
    logic          partner_an_able;
    logic          an_restart;
    logic          np_sent_stb;
    anr_np_word_t  np_tx_word;
    anr_np_word_t  sent_q;
    logic          irq;
    int            n_errors = 0;
    int            cmp_count = 0;
    logic [15:0]   w;
    logic [31:0]   d;
    logic          e;

    // 200 MHz
    always #2.5 clk_sys = ~clk_sys;

    anr_regs DUT (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .page_rx_stb(page_rx_stb), .page_rx(page_rx), .par_fault_stb(par_fault_stb),
        .partner_an_able(partner_an_able), .an_restart(an_restart), .np_sent_stb(np_sent_stb),
        .np_tx_word(np_tx_word), .irq(irq)
    );

    anr_engine_model eng (
        .clk_sys(clk_sys), .page_rx_stb(page_rx_stb), .page_rx(page_rx),
        .par_fault_stb(par_fault_stb), .partner_an_able(partner_an_able),
        .an_restart(an_restart), .np_sent_stb(np_sent_stb), .np_tx_word(np_tx_word),
        .sent_q(sent_q)
    );

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // entered just after an edge; one idle cycle after, so strobes never double up
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            n_errors++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, wd, rd, err);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp,
                          input logic [31:0] m = 32'hFFFF_FFFF);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd & m, exp);
        // a mapped, aligned read never answers with an error
        chk({31'h0, err}, 32'h0);
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        // reset state; word on the line carries the inverted toggle
        rd_chk(A_NP, 32'h2001);
        chk({16'h0, np_tx_word}, 32'h2801);
        rd_chk(A_PA, 32'h0, 32'hFFFF_5000);
        rd_chk(A_EX, 32'h4);
        $display("reset test done");
        // every pause code, varied technology and partner flags
        for (int p = 0; p < 4; p++) begin
            w = {p[0], 1'b0, p[1], 1'b1, 2'(p), 5'h10 >> p, 5'h01};
            eng.set_able(p[1]);
            eng.send_page(1'b1, w);
            rd_chk(A_EX, {28'h0, p[0], 2'b11, p[1]});
            rd_chk(A_EX, {28'h0, p[0], 2'b10, p[1]});
            rd_chk(A_PA, {16'h0, w ^ 16'h5000});
        end
        // a next page and a write to the read-only image leave it alone
        eng.send_page(1'b0, 16'h0);
        wr(A_PA, 32'h0);
        rd_chk(A_PA, {16'h0, w ^ 16'h5000});
        rd_chk(A_EX, 32'h2, 32'h2);
        eng.pulse(0);
        rd_chk(A_EX, 32'h10, 32'h10);
        rd_chk(A_EX, 32'h0, 32'h10);
        $display("partner page test done");
        // host-built next page, then one transmitted
        wr(A_NP, 32'hFFFF_FFFF);
        rd_chk(A_NP, 32'hB7FF);
        eng.pulse(1);
        rd_chk(A_NP, 32'hBFFF);
        chk({16'h0, sent_q}, 32'hBFFF);
        chk({16'h0, np_tx_word}, 32'hB7FF);
        wr(A_NP, 32'h0);
        rd_chk(A_NP, 32'h0800);
        $display("next page test done");
        // sticky events, mask and write-one-to-clear
        chk({31'h0, irq}, 32'h0);
        wr(A_IM, 32'h7);
        chk({31'h0, irq}, 32'h1);
        rd_chk(A_IS, 32'h7);
        wr(A_IS, 32'h1);
        rd_chk(A_IS, 32'h6);
        wr(A_IM, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(A_IS, 32'h6);
        rd_chk(A_IS, 32'h0);
        rd_chk(A_IM, 32'h1);
        // unmapped place answers with an error and zero
        apb(1'b0, 16'h0440, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
        chk(d, 32'h0);
        // a misaligned byte address inside a register is refused as well
        apb(1'b0, A_PA | 16'h0002, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
        chk(d, 32'h0);
        $display("interrupt test done");
        // restart forgets the partner ack bit and the toggle
        eng.pulse(2);
        rd_chk(A_PA, 32'h0, 32'h4000);
        rd_chk(A_NP, 32'h0);
        $display("restart test done");
        finish_test();
    end
endmodule
